//--- common/ussm_pkg.sv
// constants of the synchronous slave serial port
package ussm_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_INTCTL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_ENABLES = 8'h08;
    localparam logic [7:0] OFS_PRIO = 8'h0C;
    localparam logic [7:0] OFS_RXSTAT = 8'h10;
    localparam logic [7:0] OFS_TXBUF = 8'h14;
    localparam logic [7:0] OFS_TXSTAT = 8'h18;
    localparam logic [7:0] OFS_DIVISOR = 8'h1C;
    localparam logic [7:0] OFS_RXBUF = 8'h20;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int B_GLOBAL_IE = 7;
    localparam int B_PERIPH_IE = 6;
    localparam int B_RX_FULL = 5;
    localparam int B_TX_EMPTY = 4;
    localparam int B_PORT_EN = 7;
    localparam int B_RX_NINE = 6;
    localparam int B_SINGLE_RX = 5;
    localparam int B_CONT_RX = 4;
    localparam int B_FRAME_ERR = 2;
    localparam int B_OVERRUN = 1;
    localparam int B_RX_NINTH = 0;
    localparam int B_CLK_SRC = 7;
    localparam int B_TX_NINE = 6;
    localparam int B_TX_EN = 5;
    localparam int B_SYNC = 4;
    localparam int B_TRMT = 1;
    localparam int B_TX_NINTH = 0;
    // --------------------------------------------------------------
    // write masks and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RXSTAT_WMASK = 8'hF8;
    localparam logic [7:0] TXSTAT_WMASK = 8'hF5;
    localparam logic [7:0] FLAGS_WMASK = 8'hCF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
endpackage

//--- hdl/ussm_core.sv
// synchronous slave serial port with apb register access
//
// Contract
// - shift and buffer as master mode does
// - single receive enable ignored in slave
// - first word loads shift register at once
// - second word waits, buffer empty flag clear
// - load second word, then set empty flag
// - tx flag wakes core; vector needs global
// - transmit starts only when buffer loaded
// - continuous receive works while asleep
// - finished word moves to buffer, wakes
// - full flag per word, request if enabled
// - status holds ninth bit, errors; buffer data
// - clearing continuous receive clears errors
// - shift clock comes from the partner
// - sample data on falling clock edge
// - empty flag cleared only by buffer write
`timescale 1ns/10ps
`default_nettype none
module ussm_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shift_clk_in,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    input wire logic core_asleep,
    output logic wake,
    output logic irq
);
    typedef struct packed {
        logic ck_s1;
        logic ck_s2;
        logic ck_d;
        logic dt_s1;
        logic dt_s2;
        logic [7:0] intctl;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [7:0] prio;
        logic [7:0] rxstat;
        logic [7:0] txstat;
        logic [7:0] divisor;
        logic [7:0] txbuf;
        logic tx_full;
        logic [8:0] tx_shift;
        logic tx_busy;
        logic [3:0] tx_cnt;
        logic [8:0] rx_shift;
        logic [3:0] rx_cnt;
        logic [7:0] rxbuf;
        logic rx_ninth;
        logic rx_full;
        logic overrun;
        logic rdy;
        logic [31:0] rdata;
        logic err;
        logic dout;
        logic doe;
        logic wk;
        logic irq;
    } ussm_state_t;

    ussm_state_t s_reg;
    ussm_state_t s_next;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= ussm_pkg::OFS_RXBUF) && (a[1:0] == 2'b00);
    endfunction

    logic active;
    logic ck_fall;
    logic bus_ok;
    logic wr;
    logic rd;
    logic [3:0] tx_len;
    logic [3:0] rx_len;
    logic tx_empty;
    logic rx_done;
    logic [7:0] rx_word;
    logic [7:0] flags_rd;
    logic [7:0] rxstat_rd;
    logic [7:0] txstat_rd;
    logic pend;

    // slave only when sync and port enabled and clock source external
    assign active = s_reg.rxstat[ussm_pkg::B_PORT_EN] && s_reg.txstat[ussm_pkg::B_SYNC]
        && !s_reg.txstat[ussm_pkg::B_CLK_SRC];
    assign ck_fall = s_reg.ck_d && !s_reg.ck_s2;
    assign bus_ok = psel && penable && s_reg.rdy && mapped(paddr);
    assign wr = bus_ok && pwrite;
    assign rd = bus_ok && !pwrite;
    assign tx_len = s_reg.txstat[ussm_pkg::B_TX_NINE] ? ussm_pkg::BITS_NINE : ussm_pkg::BITS_BYTE;
    assign rx_len = s_reg.rxstat[ussm_pkg::B_RX_NINE] ? ussm_pkg::BITS_NINE : ussm_pkg::BITS_BYTE;
    assign tx_empty = !s_reg.tx_full;
    assign rx_done = active && s_reg.rxstat[ussm_pkg::B_CONT_RX] && !s_reg.overrun && ck_fall
        && (s_reg.rx_cnt == rx_len - 4'h1);
    // last bit is still in the sampler; eight-bit words sit one place higher
    assign rx_word = s_reg.rxstat[ussm_pkg::B_RX_NINE] ? s_reg.rx_shift[8:1]
        : {s_reg.dt_s2, s_reg.rx_shift[8:2]};
    assign pend = (tx_empty && s_reg.enables[ussm_pkg::B_TX_EMPTY])
        || (s_reg.rx_full && s_reg.enables[ussm_pkg::B_RX_FULL]);

    always_comb begin
        flags_rd = s_reg.flags & ussm_pkg::FLAGS_WMASK;
        flags_rd[ussm_pkg::B_TX_EMPTY] = tx_empty;
        flags_rd[ussm_pkg::B_RX_FULL] = s_reg.rx_full;
        rxstat_rd = s_reg.rxstat & ussm_pkg::RXSTAT_WMASK;
        rxstat_rd[ussm_pkg::B_OVERRUN] = s_reg.overrun;
        rxstat_rd[ussm_pkg::B_FRAME_ERR] = 1'b0;
        rxstat_rd[ussm_pkg::B_RX_NINTH] = s_reg.rx_ninth;
        txstat_rd = s_reg.txstat & ussm_pkg::TXSTAT_WMASK;
        txstat_rd[ussm_pkg::B_TRMT] = !s_reg.tx_busy;
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // first stage feeds only the second
        s_next.ck_s1 = shift_clk_in;
        s_next.ck_s2 = s_reg.ck_s1;
        s_next.ck_d = s_reg.ck_s2;
        s_next.dt_s1 = data_in;
        s_next.dt_s2 = s_reg.dt_s1;

        // apb: one wait state so read data leaves a flop
        s_next.rdy = psel && penable && !s_reg.rdy;
        s_next.err = psel && penable && !s_reg.rdy && !mapped(paddr);
        if (psel && penable && !s_reg.rdy) begin
            case (paddr)
                ussm_pkg::OFS_INTCTL: s_next.rdata = {24'h0, s_reg.intctl};
                ussm_pkg::OFS_FLAGS: s_next.rdata = {24'h0, flags_rd};
                ussm_pkg::OFS_ENABLES: s_next.rdata = {24'h0, s_reg.enables};
                ussm_pkg::OFS_PRIO: s_next.rdata = {24'h0, s_reg.prio};
                ussm_pkg::OFS_RXSTAT: s_next.rdata = {24'h0, rxstat_rd};
                ussm_pkg::OFS_TXBUF: s_next.rdata = {24'h0, s_reg.txbuf};
                ussm_pkg::OFS_TXSTAT: s_next.rdata = {24'h0, txstat_rd};
                ussm_pkg::OFS_DIVISOR: s_next.rdata = {24'h0, s_reg.divisor};
                ussm_pkg::OFS_RXBUF: s_next.rdata = {24'h0, s_reg.rxbuf};
                default: s_next.rdata = 32'h0;
            endcase
        end

        if (wr) begin
            case (paddr)
                ussm_pkg::OFS_INTCTL: s_next.intctl = pwdata[7:0];
                ussm_pkg::OFS_FLAGS: s_next.flags = pwdata[7:0] & ussm_pkg::FLAGS_WMASK;
                ussm_pkg::OFS_ENABLES: s_next.enables = pwdata[7:0];
                ussm_pkg::OFS_PRIO: s_next.prio = pwdata[7:0];
                ussm_pkg::OFS_RXSTAT: s_next.rxstat = pwdata[7:0] & ussm_pkg::RXSTAT_WMASK;
                ussm_pkg::OFS_TXBUF: begin
                    s_next.txbuf = pwdata[7:0];
                    s_next.tx_full = 1'b1;
                end
                ussm_pkg::OFS_TXSTAT: s_next.txstat = pwdata[7:0] & ussm_pkg::TXSTAT_WMASK;
                ussm_pkg::OFS_DIVISOR: s_next.divisor = pwdata[7:0];
                default: s_next.flags = s_reg.flags;
            endcase
        end

        // ----------------------------------------------------------
        // transmitter
        // ----------------------------------------------------------
        if (s_reg.tx_busy && active && ck_fall) begin
            s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
            s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
            if (s_reg.tx_cnt == tx_len - 4'h1) begin
                s_next.tx_busy = 1'b0;
            end
        end
        // buffer moves only into an idle shift register
        if (!s_reg.tx_busy && s_reg.tx_full && active && s_reg.txstat[ussm_pkg::B_TX_EN]) begin
            s_next.tx_shift = {s_reg.txstat[ussm_pkg::B_TX_NINTH], s_reg.txbuf};
            s_next.tx_busy = 1'b1;
            s_next.tx_cnt = 4'h0;
            s_next.tx_full = wr && (paddr == ussm_pkg::OFS_TXBUF);
        end
        s_next.dout = s_next.tx_busy ? s_next.tx_shift[0] : 1'b0;
        s_next.doe = active && s_reg.txstat[ussm_pkg::B_TX_EN];

        // ----------------------------------------------------------
        // receiver; single receive enable plays no part here
        // ----------------------------------------------------------
        if (rd && paddr == ussm_pkg::OFS_RXBUF) begin
            s_next.rx_full = 1'b0;
        end
        // no sleep gating: the partner's clock alone drives reception
        if (active && s_reg.rxstat[ussm_pkg::B_CONT_RX] && !s_reg.overrun && ck_fall) begin
            s_next.rx_shift = {s_reg.dt_s2, s_reg.rx_shift[8:1]};
            s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
            if (rx_done) begin
                s_next.rx_cnt = 4'h0;
                if (s_reg.rx_full && !(rd && paddr == ussm_pkg::OFS_RXBUF)) begin
                    s_next.overrun = 1'b1;
                end else begin
                    s_next.rxbuf = rx_word;
                    s_next.rx_ninth = s_reg.rxstat[ussm_pkg::B_RX_NINE] ? s_reg.dt_s2 : 1'b0;
                    s_next.rx_full = 1'b1;
                end
            end
        end
        if (!s_next.rxstat[ussm_pkg::B_CONT_RX]) begin
            s_next.overrun = 1'b0;
            s_next.rx_cnt = 4'h0;
        end

        // sleep does not stop the port, only the core
        s_next.wk = core_asleep && pend;
        s_next.irq = pend && s_reg.intctl[ussm_pkg::B_GLOBAL_IE] && s_reg.intctl[ussm_pkg::B_PERIPH_IE];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.rdata;
    assign pready = s_reg.rdy;
    assign pslverr = s_reg.err;
    assign data_out = s_reg.dout;
    assign data_oe = s_reg.doe;
    assign wake = s_reg.wk;
    assign irq = s_reg.irq;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_load_first;
        @(posedge pclk) disable iff (!presetn)
        (!s_reg.tx_busy && s_reg.tx_full && active && s_reg.txstat[ussm_pkg::B_TX_EN]) |=> s_reg.tx_busy;
    endproperty
    a_load_first: assert property (p_load_first) else $error("buffer not loaded into idle shifter");

    property p_hold_second;
        @(posedge pclk) disable iff (!presetn)
        (s_reg.tx_busy && s_reg.tx_full && !ck_fall) |=> s_reg.tx_full;
    endproperty
    a_hold_second: assert property (p_hold_second) else $error("second word left buffer early");

    property p_flag_after;
        @(posedge pclk) disable iff (!presetn)
        $rose(tx_empty) |-> $rose(s_reg.tx_busy);
    endproperty
    a_flag_after: assert property (p_flag_after) else $error("empty flag set without a load");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(tx_empty) |-> $past(wr) && $past(paddr) == ussm_pkg::OFS_TXBUF;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("empty flag cleared without write");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (core_asleep && tx_empty && s_reg.enables[ussm_pkg::B_TX_EMPTY]) |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on transmit flag");

    property p_rx_full;
        @(posedge pclk) disable iff (!presetn)
        (rx_done && !s_reg.rx_full) |=> s_reg.rx_full && s_reg.rxbuf == $past(rx_word);
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("received word not delivered");

    property p_err_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ussm_pkg::OFS_RXSTAT && !pwdata[ussm_pkg::B_CONT_RX])
            |=> !s_reg.overrun && s_reg.rx_cnt == 4'h0;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("overrun kept without receive");

    property p_no_rise;
        @(posedge pclk) disable iff (!presetn)
        !ck_fall |=> s_reg.rx_cnt == $past(s_reg.rx_cnt) || s_reg.rx_cnt == 4'h0;
    endproperty
    a_no_rise: assert property (p_no_rise) else $error("receiver moved off a falling edge");

    property p_apb;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer not after one wait");

    c_tx: cover property (@(posedge pclk) disable iff (!presetn) $fell(s_reg.tx_busy));
    c_rx: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_reg.rx_full));
    c_ovr: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_reg.overrun));
endmodule
`default_nettype wire

//--- test/ussm_partner.sv
// external synchronous master that drives the shift clock and the data line into the port, and samples the port's data line
`timescale 1ns/10ps
`default_nettype none
module ussm_partner (
    output logic shift_clk,
    output logic data_to_dut,
    input wire logic data_from_dut
);
    // clock parks high between frames, so each bit starts with a falling edge
    initial begin
        shift_clk = 1'b1;
        data_to_dut = 1'b0;
    end
    // ------------------------------------------------------------------
    // one frame; half is the half period in ns, 40 gives the 80 ns rate
    // ------------------------------------------------------------------
    task automatic frame(input logic [8:0] tx, input int nbits, input int half, output logic [8:0] rx);
        rx = 9'h000;
        // keep link edges clear of the core clock's rising edges
        #2;
        for (int i = 0; i < nbits; i++) begin
            data_to_dut = tx[i];
            #(half);
            rx[i] = data_from_dut;
            shift_clk = 1'b0;
            #(half);
            shift_clk = 1'b1;
        end
        // no pull on the line: show the opposite of the last bit once released
        data_to_dut = ~data_to_dut;
    endtask
endmodule
`default_nettype wire

//--- test/tb_usart_sync_slave_mode.sv
// self-checking bench of the synchronous slave serial port
`timescale 1ns/10ps
`default_nettype none
module tb_usart_sync_slave_mode;
    localparam logic [31:0] SYNC_B = 32'h1 << ussm_pkg::B_SYNC;
    localparam logic [31:0] TX_EN_B = 32'h1 << ussm_pkg::B_TX_EN;
    localparam logic [31:0] TX_NINE_B = 32'h1 << ussm_pkg::B_TX_NINE;
    localparam logic [31:0] TRMT_B = 32'h1 << ussm_pkg::B_TRMT;
    localparam logic [31:0] PORT_EN_B = 32'h1 << ussm_pkg::B_PORT_EN;
    localparam logic [31:0] RX_NINE_B = 32'h1 << ussm_pkg::B_RX_NINE;
    localparam logic [31:0] SINGLE_RX_B = 32'h1 << ussm_pkg::B_SINGLE_RX;
    localparam logic [31:0] CONT_RX_B = 32'h1 << ussm_pkg::B_CONT_RX;
    localparam logic [31:0] OVERRUN_B = 32'h1 << ussm_pkg::B_OVERRUN;
    logic pclk, presetn, psel, penable, pwrite, core_asleep;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, shift_clk, data_in, data_out, data_oe, wake, irq;
    int fail_count = 0;
    int samples_checked = 0;
    logic [7:0] rst_exp [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

    ussm_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shift_clk_in(shift_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .core_asleep(core_asleep), .wake(wake), .irq(irq));
    ussm_partner far_end (.shift_clk(shift_clk), .data_to_dut(data_in), .data_from_dut(data_out));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] flags_exp(input logic rx_full, input logic tx_empty);
        return {26'h0, rx_full, tx_empty, 4'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // answer taken at the edge where pready is seen high
        r = prdata;
        e = pslverr;
        if (n >= 50) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        logic [8:0] rx, d, d1;
        logic [7:0] a, b;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        core_asleep = 1'b0;
        presetn = 1'b0;
        void'($urandom(32'hAB5C2C00));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd_check(8'(4 * i), {24'h0, rst_exp[i]});
        // refused places: unmapped and misaligned
        apb(1'b0, 8'h24, 32'h0, r, e);
        check({e, r[30:0]}, 32'h80000000);
        apb(1'b1, 8'h02, 32'hFF, r, e);
        check({31'h0, e}, 32'h1);
        repeat (4) begin
            a = 8'($urandom);
            wr(ussm_pkg::OFS_DIVISOR, {24'h0, a});
            rd_check(ussm_pkg::OFS_DIVISOR, {24'h0, a});
            wr(ussm_pkg::OFS_PRIO, {24'h0, ~a});
            rd_check(ussm_pkg::OFS_PRIO, {24'h0, ~a});
        end
        // two words queued, core asleep
        wr(ussm_pkg::OFS_TXSTAT, SYNC_B | TX_EN_B);
        wr(ussm_pkg::OFS_RXSTAT, PORT_EN_B);
        wr(ussm_pkg::OFS_ENABLES, 32'h10);
        rd_check(ussm_pkg::OFS_TXSTAT, SYNC_B | TX_EN_B | TRMT_B);
        check({31'h0, data_oe}, 32'h1);
        a = 8'($urandom);
        b = 8'($urandom);
        wr(ussm_pkg::OFS_TXBUF, {24'h0, a});
        wr(ussm_pkg::OFS_TXBUF, {24'h0, b});
        core_asleep <= 1'b1;
        rd_check(ussm_pkg::OFS_FLAGS, flags_exp(1'b0, 1'b0));
        rd_check(ussm_pkg::OFS_TXSTAT, SYNC_B | TX_EN_B);
        check({31'h0, wake}, 32'h0);
        far_end.frame(9'h0AA, 8, 40, rx);
        check({24'h0, rx[7:0]}, {24'h0, a});
        settle();
        rd_check(ussm_pkg::OFS_FLAGS, flags_exp(1'b0, 1'b1));
        check({30'h0, wake, irq}, 32'h2);
        wr(ussm_pkg::OFS_INTCTL, 32'hC0);
        settle();
        check({31'h0, irq}, 32'h1);
        wr(ussm_pkg::OFS_FLAGS, 32'h00);
        rd_check(ussm_pkg::OFS_FLAGS, flags_exp(1'b0, 1'b1));
        far_end.frame(9'h155, 8, 40, rx);
        check({24'h0, rx[7:0]}, {24'h0, b});
        settle();
        rd_check(ussm_pkg::OFS_TXSTAT, SYNC_B | TX_EN_B | TRMT_B);
        // nine-bit word, ninth bit last
        wr(ussm_pkg::OFS_TXSTAT, SYNC_B | TX_EN_B | TX_NINE_B | 32'h1);
        a = 8'($urandom);
        wr(ussm_pkg::OFS_TXBUF, {24'h0, a});
        far_end.frame(9'h000, 9, 40, rx);
        check({23'h0, rx}, {23'h0, 1'b1, a});
        // reception while asleep; single receive enable alone does nothing
        wr(ussm_pkg::OFS_TXSTAT, SYNC_B);
        wr(ussm_pkg::OFS_ENABLES, 32'h20);
        wr(ussm_pkg::OFS_RXSTAT, PORT_EN_B | SINGLE_RX_B);
        check({31'h0, data_oe}, 32'h0);
        far_end.frame(9'($urandom), 8, 40, rx);
        settle();
        rd_check(ussm_pkg::OFS_FLAGS, flags_exp(1'b0, 1'b1));
        wr(ussm_pkg::OFS_RXSTAT, PORT_EN_B | SINGLE_RX_B | RX_NINE_B);
        wr(ussm_pkg::OFS_RXSTAT, PORT_EN_B | SINGLE_RX_B | RX_NINE_B | CONT_RX_B);
        repeat (2) begin
            d = 9'($urandom);
            far_end.frame(d, 9, 40, rx);
            settle();
            rd_check(ussm_pkg::OFS_FLAGS, flags_exp(1'b1, 1'b1));
            check({30'h0, wake, irq}, 32'h3);
            rd_check(ussm_pkg::OFS_RXSTAT, PORT_EN_B | SINGLE_RX_B | RX_NINE_B | CONT_RX_B | {31'h0, d[8]});
            rd_check(ussm_pkg::OFS_RXBUF, {24'h0, d[7:0]});
            settle();
            check({30'h0, wake, irq}, 32'h0);
        end
        // overrun: second word lands on a full buffer
        d1 = {1'b0, 8'($urandom)};
        far_end.frame(d1, 9, 40, rx);
        far_end.frame(9'($urandom), 9, 40, rx);
        settle();
        rd_check(ussm_pkg::OFS_RXSTAT, PORT_EN_B | SINGLE_RX_B | RX_NINE_B | CONT_RX_B | OVERRUN_B);
        rd_check(ussm_pkg::OFS_RXBUF, {24'h0, d1[7:0]});
        wr(ussm_pkg::OFS_RXSTAT, PORT_EN_B | RX_NINE_B);
        rd_check(ussm_pkg::OFS_RXSTAT, PORT_EN_B | RX_NINE_B);
        test_done();
    end
endmodule
`default_nettype wire
